// File: verilog/sls_pkg.sv
// sls_pkg: field layout, latch selects and timing constants for the
// serial latch bank of an integer-N synthesizer.
// assumes: a 24-bit word with the two latch-select bits in DB1..DB0.
package sls_pkg;

  localparam int WORD_W = 24;

  // latch select codes {latch_select_high, latch_select_low}
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_REFERENCE = 2'h1;
  localparam logic [1:0] SEL_FEEDBACK = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;

  // control latch fields
  localparam int CTL_PRESC_LSB = 22;
  localparam int CTL_PD_MODE = 21;
  localparam int CTL_PD_EN = 20;
  localparam int CTL_CUR2_LSB = 17;
  localparam int CTL_CUR1_LSB = 14;
  localparam int CTL_OPWR_LSB = 12;
  localparam int CTL_MUTE = 11;
  localparam int CTL_GAIN = 10;
  localparam int CTL_CP3STATE = 9;
  localparam int CTL_POLARITY = 8;
  localparam int CTL_MON_LSB = 5;
  localparam int CTL_CNT_RST = 4;
  localparam int CTL_CORE_LSB = 2;

  // feedback divider latch fields
  localparam int FB_DIV2_SEL = 23;
  localparam int FB_DIV2 = 22;
  localparam int FB_GAIN = 21;
  localparam int FB_MAIN_LSB = 8;
  localparam int FB_MAIN_W = 13;
  localparam int FB_SWAL_LSB = 2;
  localparam int FB_SWAL_W = 5;
  localparam int FB_RATIO_W = 18;

  // reference divider latch fields
  localparam int REF_BAND_LSB = 20;
  localparam int REF_TEST = 19;
  localparam int REF_LDP = 18;
  localparam int REF_ABL_LSB = 16;
  localparam int REF_DIV_LSB = 2;
  localparam int REF_DIV_W = 14;

  // prescaler moduli by code
  localparam logic [5:0] PRESC_MOD_0 = 6'h08;
  localparam logic [5:0] PRESC_MOD_1 = 6'h10;
  localparam logic [5:0] PRESC_MOD_2 = 6'h20;

  // lock detect
  localparam int LOCK_WINDOW_NS = 15;
  localparam logic [2:0] LOCK_CYC_FINE = 3'h5;
  localparam logic [2:0] LOCK_CYC_COARSE = 3'h3;

  // synchronous power-down waits for this many reference ticks
  localparam logic [1:0] SYNC_PD_TICKS = 2'h2;

  // host serial clock ceiling
  localparam int SER_CLK_MAX_HZ = 20_000_000;

  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;

  typedef struct packed {
    logic powered_down;
    logic cp_tristate;
    logic [2:0] cp_current;
    logic cp_gain;
    logic pos_polarity;
    logic rf_enable;
    logic ref_buf_enable;
    logic counters_load;
    logic locked;
    logic rdiv_pulse;
    logic [FB_RATIO_W-1:0] fb_ratio;
    logic div2_enable;
    logic div2_presc_sel;
    logic [1:0] prescaler;
    logic [1:0] output_power;
    logic [1:0] core_current;
    logic [2:0] monitor_select;
    logic [1:0] antibacklash;
    logic [1:0] band_clk_div;
    logic test_active;
    logic [WORD_W-1:0] test_word;
  } sls_out_s;

endpackage : sls_pkg

// File: verilog/sls_serial_latch_bank.sv
// sls_serial_latch_bank: three-wire write-only input register feeding
// the control, feedback divider and reference divider latches, plus
// the power-down, reference divider and lock detect logic they steer.
// assumes: i_ser_clk only runs while the host shifts a word, and the
// host keeps the serial clock still while the load strobe is high.
//
// Contract
// - select bits one-zero load feedback latch, zero-one load reference latch.
// - select bits both zero load the control latch.
// - bits shift on rising serial clock; load strobe rise latches the word.
// - power-down enable one with mode zero powers down on latching.
// - enable and mode both one power down on second reference tick.
// - chip enable low disables the device regardless of power bits.
// - power-down loads counters, tristates pump, clears lock, mutes RF, buffer.
// - serial register keeps loading words during power-down.
// - control latch holds two 3-bit pump current fields.
// - mute-until-lock keeps RF outputs off until lock is reported.
// - pump gain follows the latest write from control or feedback.
// - pump three-state bit one forces the pump to three-state.
// - polarity bit one positive, zero negative detector polarity.
// - counter reset bit one holds reference and feedback counters.
// - feedback latch carries a 5-bit swallow count 0 to 31.
// - feedback latch carries a 13-bit main count 3 to 8191.
// - feedback ratio equals prescaler modulus times main plus swallow.
// - feedback bit 22 one enables the output divide-by-2.
// - feedback bit 23 one feeds the halved signal to the prescaler.
// - reference latch carries a 14-bit divide ratio 1 to 16383.
// - lock after five or three good reference cycles per precision bit.
// - test bit zero ignores the factory test latch.
`timescale 1ns/1ps
`default_nettype none

module sls_serial_latch_bank
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_load_strobe,
  input wire logic i_chip_en,
  input wire logic i_phase_err_small,
  output logic [sls_pkg::WORD_W-1:0] o_shift_word,
  output sls_pkg::sls_out_s o_cfg
);

  // serial clock domain
  typedef struct packed {
    logic [sls_pkg::WORD_W-1:0] shreg;
  } sls_link_s;

  // reference clock domain
  typedef struct packed {
    logic [1:0] le_sync;
    logic le_prev;
    logic [1:0] ce_sync;
    logic [sls_pkg::WORD_W-1:0] ctl;
    logic [sls_pkg::WORD_W-1:0] fbk;
    logic [sls_pkg::WORD_W-1:0] refl;
    logic [sls_pkg::WORD_W-1:0] tst;
    logic gain;
    logic sync_pend;
    logic [1:0] tick_cnt;
    logic soft_pd;
    logic [sls_pkg::REF_DIV_W-1:0] rcnt;
    logic rtick;
    logic [2:0] lock_cnt;
    logic locked;
    logic [sls_pkg::WORD_W-1:0] shadow;
    sls_pkg::sls_out_s out;
  } sls_state_s;

  localparam int FB_W = sls_pkg::FB_RATIO_W;

  sls_link_s link_q;
  sls_link_s link_d;
  sls_state_s st_q;
  sls_state_s st_d;

  // ---------------------------------------------------------------
  // link side: plain shifter, first bit ends up in DB23
  // ---------------------------------------------------------------
  always_comb
  begin
    link_d = link_q;
    link_d.shreg = {link_q.shreg[sls_pkg::WORD_W-2:0], i_ser_data};
  end

  // the shifter has no power-down gate, so it keeps working
  always_ff @(posedge i_ser_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      link_q <= '0;
    else
      link_q <= link_d;
  end

  // ---------------------------------------------------------------
  // reference side
  // ---------------------------------------------------------------
  logic le_rise;
  logic [1:0] sel;
  logic [sls_pkg::WORD_W-1:0] word;
  logic pd_now;
  logic cnt_hold;
  logic [sls_pkg::REF_DIV_W-1:0] rdiv;
  logic [2:0] lock_need;
  logic [5:0] presc_mod;
  logic [sls_pkg::FB_MAIN_W-1:0] main_cnt;
  logic [sls_pkg::FB_SWAL_W-1:0] swal_cnt;
  logic gain_eff;

  always_comb
  begin
    st_d = st_q;

    // pin synchronisers
    st_d.le_sync = {st_q.le_sync[0], i_load_strobe};
    st_d.ce_sync = {st_q.ce_sync[0], i_chip_en};
    st_d.le_prev = st_q.le_sync[1];
    le_rise = st_q.le_sync[1] & ~st_q.le_prev;

    // shift word is quasi-static once the strobe is high; sampling it
    // only on the synchronised rise keeps the crossing clean as long
    // as the host holds the serial clock still meanwhile
    word = link_q.shreg;
    sel = word[1:0];
    st_d.shadow = st_q.shadow;

    // latch transfer on strobe rise, independent of power state
    if (le_rise)
    begin
      st_d.shadow = word;
      if (sel == sls_pkg::SEL_CONTROL)
      begin
        st_d.ctl = word;
        st_d.gain = word[sls_pkg::CTL_GAIN];
        if (!word[sls_pkg::CTL_PD_EN])
        begin
          st_d.soft_pd = 1'b0;
          st_d.sync_pend = 1'b0;
        end
        else if (!word[sls_pkg::CTL_PD_MODE])
        begin
          st_d.soft_pd = 1'b1;
          st_d.sync_pend = 1'b0;
        end
        else if (!st_q.soft_pd)
        begin
          // wait for the pump to finish before dropping power
          st_d.sync_pend = 1'b1;
          st_d.tick_cnt = 2'h0;
        end
      end
      else if (sel == sls_pkg::SEL_FEEDBACK)
      begin
        st_d.fbk = word;
        st_d.gain = word[sls_pkg::FB_GAIN];
      end
      else if (sel == sls_pkg::SEL_REFERENCE)
      begin
        st_d.refl = word;
      end
      else if (st_q.refl[sls_pkg::REF_TEST])
      begin
        st_d.tst = word;
      end
    end

    // synchronous power-down counts reference ticks after the strobe
    if (st_q.sync_pend && st_q.rtick && !le_rise)
    begin
      if (st_q.tick_cnt == sls_pkg::SYNC_PD_TICKS - 2'h1)
      begin
        st_d.soft_pd = 1'b1;
        st_d.sync_pend = 1'b0;
      end
      else
      begin
        st_d.tick_cnt = st_q.tick_cnt + 2'h1;
      end
    end

    // chip enable low wins over everything
    pd_now = ~st_q.ce_sync[1] | st_q.soft_pd;
    cnt_hold = pd_now | st_q.ctl[sls_pkg::CTL_CNT_RST];

    // reference divider; a zero ratio behaves as one
    rdiv = st_q.refl[sls_pkg::REF_DIV_LSB +: sls_pkg::REF_DIV_W];
    if (rdiv == '0)
      rdiv = 14'h0001;
    st_d.rtick = 1'b0;
    if (cnt_hold)
    begin
      st_d.rcnt = '0;
    end
    else if (st_q.rcnt >= rdiv - 14'h0001)
    begin
      st_d.rcnt = '0;
      st_d.rtick = 1'b1;
    end
    else
    begin
      st_d.rcnt = st_q.rcnt + 14'h0001;
    end

    // lock detector: consecutive good reference cycles
    lock_need = st_q.refl[sls_pkg::REF_LDP] ? sls_pkg::LOCK_CYC_FINE
                                            : sls_pkg::LOCK_CYC_COARSE;
    if (pd_now)
    begin
      st_d.lock_cnt = 3'h0;
      st_d.locked = 1'b0;
    end
    else if (st_q.rtick)
    begin
      if (!i_phase_err_small)
      begin
        st_d.lock_cnt = 3'h0;
        st_d.locked = 1'b0;
      end
      else if (st_q.lock_cnt + 3'h1 >= lock_need)
      begin
        st_d.lock_cnt = lock_need;
        st_d.locked = 1'b1;
      end
      else
      begin
        st_d.lock_cnt = st_q.lock_cnt + 3'h1;
      end
    end

    // feedback ratio
    case (st_q.ctl[sls_pkg::CTL_PRESC_LSB +: 2])
      2'h0: presc_mod = sls_pkg::PRESC_MOD_0;
      2'h1: presc_mod = sls_pkg::PRESC_MOD_1;
      default: presc_mod = sls_pkg::PRESC_MOD_2;
    endcase
    main_cnt = st_q.fbk[sls_pkg::FB_MAIN_LSB +: sls_pkg::FB_MAIN_W];
    swal_cnt = st_q.fbk[sls_pkg::FB_SWAL_LSB +: sls_pkg::FB_SWAL_W];
    gain_eff = st_q.gain;

    // registered outputs
    st_d.out.powered_down = pd_now;
    st_d.out.counters_load = cnt_hold;
    st_d.out.cp_tristate = pd_now | st_q.ctl[sls_pkg::CTL_CP3STATE];
    // two current fields, gain picks one
    st_d.out.cp_current = gain_eff ? st_q.ctl[sls_pkg::CTL_CUR2_LSB +: 3]
                                   : st_q.ctl[sls_pkg::CTL_CUR1_LSB +: 3];
    st_d.out.cp_gain = gain_eff;
    st_d.out.pos_polarity = st_q.ctl[sls_pkg::CTL_POLARITY];
    // outputs muted in power-down and, if asked, until lock
    st_d.out.rf_enable = ~pd_now &
      (~st_q.ctl[sls_pkg::CTL_MUTE] | st_q.locked);
    st_d.out.ref_buf_enable = ~pd_now;
    st_d.out.locked = st_q.locked & ~pd_now;
    st_d.out.rdiv_pulse = st_q.rtick;
    st_d.out.fb_ratio = FB_W'(presc_mod) * FB_W'(main_cnt)
                        + FB_W'(swal_cnt);
    st_d.out.div2_enable = st_q.fbk[sls_pkg::FB_DIV2];
    st_d.out.div2_presc_sel = st_q.fbk[sls_pkg::FB_DIV2_SEL];
    st_d.out.prescaler = st_q.ctl[sls_pkg::CTL_PRESC_LSB +: 2];
    // fields passed through untouched
    st_d.out.output_power = st_q.ctl[sls_pkg::CTL_OPWR_LSB +: 2];
    st_d.out.core_current = st_q.ctl[sls_pkg::CTL_CORE_LSB +: 2];
    st_d.out.monitor_select = st_q.ctl[sls_pkg::CTL_MON_LSB +: 3];
    st_d.out.antibacklash = st_q.refl[sls_pkg::REF_ABL_LSB +: 2];
    st_d.out.band_clk_div = st_q.refl[sls_pkg::REF_BAND_LSB +: 2];
    // test latch contents invisible while the test bit is clear
    st_d.out.test_active = st_q.refl[sls_pkg::REF_TEST];
    st_d.out.test_word = st_q.refl[sls_pkg::REF_TEST] ? st_q.tst
                                                      : sls_pkg::LATCH_RESET;
  end

  // latches have no documented reset; zero is a defined start and
  // leaves the part powered up with counters running from ratio one
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_cfg = st_q.out;
  assign o_shift_word = st_q.shadow;

endmodule : sls_serial_latch_bank

`default_nettype wire

// File: tb/sls_host_model.sv
// host model: shifts 24-bit words msb first, then raises the strobe
// assumes: caller waits for the latch to settle after each write
`timescale 1ns/1ps
`default_nettype none
module sls_host_model
(
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_load_strobe
);
  initial
  begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_load_strobe = 1'b0;
  end
  task automatic write(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      o_ser_data = w[i];
      #62.5 o_ser_clk = 1'b1; // 8 MHz link clock
      #62.5 o_ser_clk = 1'b0;
    end
    // released data flips so a late sample cannot pass
    o_ser_data = ~o_ser_data;
    o_load_strobe = 1'b1; // clock still while high
    #600 o_load_strobe = 1'b0;
  endtask : write
endmodule : sls_host_model
`default_nettype wire

// File: tb/sls_serial_latch_bank_sva.sv
// checker: latch bank relations seen at the ports, reference clock
// assumes: bound to every sls_serial_latch_bank instance
`timescale 1ns/1ps
`default_nettype none
module sls_latch_chk
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_load_strobe,
  input wire logic i_chip_en,
  input wire logic i_phase_err_small,
  input wire logic [sls_pkg::WORD_W-1:0] o_shift_word,
  input wire sls_pkg::sls_out_s o_cfg
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  logic [23:0] w;
  logic [5:0] md;
  assign w = o_shift_word;
  assign md = (o_cfg.prescaler == 2'h0) ? 6'h08 :
    (o_cfg.prescaler == 2'h1) ? 6'h10 : 6'h20;
  sequence s_new(logic [1:0] sel);
    $changed(o_shift_word) && o_shift_word[1:0] == sel;
  endsequence
  property p_pd;
    o_cfg.powered_down |-> o_cfg.cp_tristate && o_cfg.counters_load &&
      !o_cfg.locked && !o_cfg.rf_enable && !o_cfg.ref_buf_enable;
  endproperty
  property p_ce;
    $fell(i_chip_en) |-> ##[1:4] o_cfg.powered_down;
  endproperty
  property p_async;
    s_new(2'h0) ##0 (w[20] && !w[21]) |=> o_cfg.powered_down;
  endproperty
  property p_ctl;
    s_new(2'h0) |=> o_cfg.pos_polarity == w[8] &&
      o_cfg.cp_gain == w[10] && (!w[9] || o_cfg.cp_tristate);
  endproperty
  property p_cur;
    s_new(2'h0) |=> o_cfg.cp_current == (w[10] ? w[19:17] : w[16:14]);
  endproperty
  property p_cnt;
    s_new(2'h0) ##0 w[4] |=> o_cfg.counters_load;
  endproperty
  property p_fld;
    s_new(2'h0) |=> o_cfg.output_power == w[13:12] &&
      o_cfg.core_current == w[3:2] && o_cfg.monitor_select == w[7:5];
  endproperty
  property p_fb;
    s_new(2'h2) |=> o_cfg.div2_enable == w[22] &&
      o_cfg.div2_presc_sel == w[23] && o_cfg.cp_gain == w[21];
  endproperty
  property p_ratio;
    s_new(2'h2) |=> o_cfg.fb_ratio == md * w[20:8] + w[6:2];
  endproperty
  property p_ref;
    s_new(2'h1) |=> o_cfg.antibacklash == w[17:16] &&
      o_cfg.band_clk_div == w[21:20] && o_cfg.test_active == w[19];
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down side effects missing");
  a_ce: assert property (p_ce)
    else $error("chip enable low did not power down");
  a_async: assert property (p_async)
    else $error("async power-down not immediate");
  a_ctl: assert property (p_ctl)
    else $error("control bits not applied");
  a_cur: assert property (p_cur)
    else $error("pump current field wrong");
  a_cnt: assert property (p_cnt)
    else $error("counter reset not held");
  a_fld: assert property (p_fld)
    else $error("control pass-through field wrong");
  a_fb: assert property (p_fb)
    else $error("feedback bits not applied");
  a_ratio: assert property (p_ratio)
    else $error("feedback ratio wrong");
  a_ref: assert property (p_ref)
    else $error("reference fields wrong");
endmodule : sls_latch_chk
bind sls_serial_latch_bank sls_latch_chk u_sls_latch_chk
(
  .i_ref_clk, .i_nrst, .i_ser_clk, .i_ser_data, .i_load_strobe,
  .i_chip_en, .i_phase_err_small, .o_shift_word, .o_cfg
);
`default_nettype wire

// File: tb/tb_top.sv
// testbench: serial writes through the host model, checks on o_cfg
// assumes: sls_pkg compiled first, checker bound from its own file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, nrst, chip_en, ph_ok, sck, sdata, strobe;
  logic [23:0] shift_word;
  sls_pkg::sls_out_s cfg;
  int fail_count = 0;
  int compares = 0;
  int n, k;
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  sls_host_model u_sls_host_model
  (
    .o_ser_clk(sck),
    .o_ser_data(sdata),
    .o_load_strobe(strobe)
  );
  sls_serial_latch_bank u_sls_serial_latch_bank
  (
    .i_ref_clk(ref_clk),
    .i_nrst(nrst),
    .i_ser_clk(sck),
    .i_ser_data(sdata),
    .i_load_strobe(strobe),
    .i_chip_en(chip_en),
    .i_phase_err_small(ph_ok),
    .o_shift_word(shift_word),
    .o_cfg(cfg)
  );
  task automatic test_done;
    $display("compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [23:0] w);
    u_sls_host_model.write(w);
    repeat (2) @(negedge ref_clk);
  endtask : wr
  task automatic endt;
    k++;
    $display("test %0d done", k);
  endtask : endt
  // waits for power-down, lim bounds the wait
  task automatic wait_pd(input int lim);
    n = 0;
    while (cfg.powered_down !== 1'b1 && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= lim)
    begin
      chk(0, 1);
      test_done();
    end
  endtask : wait_pd
  // counts reference ticks until lock is reported
  task automatic lock_run(input int lo);
    int i;
    i = 0;
    n = 0;
    ph_ok = 1'b1;
    while (cfg.locked !== 1'b1 && i < 3000)
    begin
      @(negedge ref_clk);
      i++;
      if (cfg.rdiv_pulse === 1'b1)
        n++;
    end
    chk(n >= lo && n <= lo + 1, 1);
    if (i >= 3000)
    begin
      chk(0, 1);
      test_done();
    end
  endtask : lock_run
  initial
  begin
    nrst = 1'b0;
    chip_en = 1'b1;
    ph_ok = 1'b0;
    k = 0;
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    wr(24'h160191); // reference first
    chk(shift_word, 24'h160191);
    chk(cfg.test_active, 0);
    chk(cfg.antibacklash, 2);
    chk(cfg.band_clk_div, 1);
    wr(24'h4AED64);
    chk(cfg.cp_current, 5);
    chk(cfg.prescaler, 1);
    chk(cfg.rf_enable, 0);
    wr(24'hC0641E);
    chk(cfg.fb_ratio, 1607);
    chk(cfg.cp_gain, 0);
    chk(cfg.cp_current, 3);
    endt();
    lock_run(5);
    repeat (2) @(negedge ref_clk);
    chk(cfg.rf_enable, 1);
    wr(24'hFFFFFF);
    chk(cfg.test_active, 0);
    chk(cfg.fb_ratio, 1607);
    chk(cfg.test_word, 0);
    endt();
    wr(24'h100010);
    chk(cfg.powered_down, 1);
    chk(cfg.locked, 0);
    wr(24'h00C80A);
    chk(cfg.fb_ratio, 1602);
    wr(24'h120191);
    ph_ok = 1'b0;
    // pump three-state alone, part powered up
    wr(24'h000200);
    chk(cfg.powered_down, 0);
    chk(cfg.cp_tristate, 1);
    lock_run(3);
    endt();
    wr(24'h300000);
    chk(cfg.powered_down, 0);
    wait_pd(300);
    chk(n > 80 && n < 210, 1);
    // counter reset alone, part powered up
    wr(24'h000010);
    chk(cfg.powered_down, 0);
    chk(cfg.counters_load, 1);
    repeat (3) @(negedge ref_clk);
    chip_en = 1'b0;
    wait_pd(5);
    chk(cfg.cp_tristate, 1);
    endt();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
